// ===== dcs_cond_model.sv
// Condition-pin model: sensors and serial checker beside the bank.
// Assumes the bench asks for each condition level on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dcs_cond_model
  import dcs_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Requested conditions
  input  wire logic [5:0]  req,
  // Pins to the bank
  output var  dcs_src_type src_pins
);
  // Launched on the rising edge, the same edge on which the bank samples the pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_pins <= 6'h20;
    end else begin
      src_pins <= req;
    end
  end
endmodule

`default_nettype wire

// ===== dcs_params.svh
// Constants for the converter calibration and status register bank.
// Assumes APB byte addresses are four times the register index.
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
`define DCS_IDX_SUPPLY   6'h07
`define DCS_IDX_CAL_EN   6'h08
`define DCS_IDX_GAIN     6'h09
`define DCS_IDX_OFFS     6'h0A
`define DCS_IDX_FLAGS    6'h0B
`define DCS_IDX_MASK     6'h0C
`define DCS_IDX_USER     6'h1E
`define DCS_RST_SUPPLY   6'h1C
`define DCS_RST_ZERO     16'h0000
`define DCS_RST_SRC      6'h20
`define DCS_IDENT_BITS   3'h5
`define DCS_BIT_LEARN    12
`define DCS_BIT_WDT      11
`define DCS_BIT_PG       7
`define DCS_BIT_TGL      6
`define DCS_BIT_CRE      5
`define DCS_BIT_TMP      4
`define DCS_BIT_FAULT    0
`define DCS_NEG_CLAMP_SELECT_MAX    4'h9
`endif

// ===== dcs_pkg.sv
// Types shared by the calibration and status register bank.
// Assumes the constants header is compiled alongside.
package dcs_pkg;
  typedef struct packed {
    logic learn_done;
    logic watchdog;
    logic supply_good;
    logic crc_fail;
    logic over_temp;
    logic out_fault;
  } dcs_src_type;
  typedef struct packed {
    logic [3:0] neg_clamp_select;
    logic [1:0] arm_select;
  } dcs_supply_type;
endpackage

// ===== dcs_regs.sv
// APB register bank: clamp/arm config, calibration, status flags, masks.
// Assumes condition pins are asynchronous; converter code and mode are
// on sys_clk.
//
// How it works
// - Negative clamp field, validity per output mode
// - Arm select field, 00 disables both arms
// - Calibration enable bit, resets off
// - Sixteen-bit gain correction, reset zero
// - Sixteen-bit offset correction, reset zero
// - Learn-done bit 12, reads one after reset
// - Bit 11 flags watchdog expiry
// - Bit 7 shows supply power good
// - Bit 6 echoes host toggle bit
// - Bit 5 flags frame integrity error
// - Bit 4 flags over temperature
// - Bit 0 flags output channel fault
// - Mask register per alarm source, reset zero
// - Masked condition leaves alarm pin, flag kept
`timescale 1ns/1ps
`default_nettype none
`include "dcs_params.svh"

module dcs_regs
  import dcs_pkg::*;
(
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output var  logic [31:0]    prdata,
  output var  logic           pready,
  output var  logic           pslverr,
  // Condition pins
  input  wire dcs_src_type    src_pins,
  // Converter datapath
  input  wire logic           voltage_mode,
  input  wire logic [15:0]    dac_code,
  output var  logic [15:0]    cal_code,
  // Supply converter controls
  output var  dcs_supply_type supply_cfg,
  output var  logic           clamp_code_valid,
  // Alarm
  output var  logic           alarm_irq
);

  // Registers
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;
  dcs_supply_type supply_q;
  logic           cal_enable_q;
  logic [15:0]    gain_correction_q;
  logic [15:0]    offset_correction_q;
  logic [15:0]    alarm_pin_masks_q;
  logic           host_toggle_bit_q;
  logic [3:0]     sticky_q;
  logic [3:0]     sticky_d;
  logic [15:0]    cal_code_q;
  logic           clamp_valid_q;
  logic           alarm_q;

  // Bus decode
  wire [5:0] idx     = paddr[7:2];
  wire       setup   = psel & ~penable;
  wire       acc     = psel & penable & pready_q;
  wire       hit_sup = (idx == `DCS_IDX_SUPPLY);
  wire       hit_cal = (idx == `DCS_IDX_CAL_EN);
  wire       hit_gn  = (idx == `DCS_IDX_GAIN);
  wire       hit_of  = (idx == `DCS_IDX_OFFS);
  wire       hit_fl  = (idx == `DCS_IDX_FLAGS);
  wire       hit_mk  = (idx == `DCS_IDX_MASK);
  wire       hit_us  = (idx == `DCS_IDX_USER);
  wire       hit     = hit_sup | hit_cal | hit_gn | hit_of | hit_fl
                     | hit_mk | hit_us;
  wire       wr_acc  = acc & pwrite & hit;
  wire       rd_acc  = acc & ~pwrite;

  // Synchronised condition levels
  localparam logic [5:0] SRC_RST = `DCS_RST_SRC;
  wire  [5:0]  filt_q;
  dcs_src_type filt;
  assign filt = filt_q;

  // Three-stage sync per pin; a level counts once stages two and three agree
  for (genvar i = 0; i < 6; i++) begin : g_sync
    logic [2:0] sh_q;
    logic       lvl_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        sh_q  <= {3{SRC_RST[i]}};
        lvl_q <= SRC_RST[i];
      end else begin
        sh_q <= {sh_q[1:0], src_pins[i]};
        if (sh_q[1] == sh_q[2]) begin
          lvl_q <= sh_q[2];
        end
      end
    end
    assign filt_q[i] = lvl_q;
  end

  // Status word view
  wire [15:0] flags_word = {
    3'h0,
    filt.learn_done,
    sticky_q[3],
    `DCS_IDENT_BITS,
    filt.supply_good,
    host_toggle_bit_q,
    sticky_q[2],
    sticky_q[1],
    3'h0,
    sticky_q[0]
  };

  // Read mux
  wire [15:0] rd_word =
      hit_sup ? {10'h000, supply_q} :
      hit_cal ? {15'h0000, cal_enable_q} :
      hit_gn  ? gain_correction_q :
      hit_of  ? offset_correction_q :
      hit_fl  ? flags_word :
      hit_mk  ? alarm_pin_masks_q :
      hit_us  ? {15'h0000, host_toggle_bit_q} : `DCS_RST_ZERO;

  // Sticky events; only bits the host actually saw are cleared
  wire       rd_clr  = rd_acc & hit_fl;
  wire [3:0] seen    = {prdata_q[`DCS_BIT_WDT], prdata_q[`DCS_BIT_CRE],
                        prdata_q[`DCS_BIT_TMP], prdata_q[`DCS_BIT_FAULT]};
  wire [3:0] events  = {filt.watchdog, filt.crc_fail,
                        filt.over_temp, filt.out_fault};
  assign sticky_d = (sticky_q & ~(seen & {4{rd_clr}})) | events;

  // Mask bits in status layout
  wire [3:0] src_mask = {alarm_pin_masks_q[`DCS_BIT_WDT],
                         alarm_pin_masks_q[`DCS_BIT_CRE],
                         alarm_pin_masks_q[`DCS_BIT_TMP],
                         alarm_pin_masks_q[`DCS_BIT_FAULT]};
  wire       alarm_d  = |(sticky_q & ~src_mask);

  // Calibration datapath
  wire [31:0] prod    = dac_code * gain_correction_q;
  wire [16:0] cal_sum = {1'b0, prod[31:16]} + {1'b0, offset_correction_q};
  wire [15:0] cal_sat = cal_sum[16] ? 16'hFFFF : cal_sum[15:0];

  // Clamp code legality
  wire [3:0] ncl = supply_q.neg_clamp_select;
  wire clamp_ok = voltage_mode
                ? (ncl == 4'h2) | (ncl == 4'h7) | (ncl == 4'h9)
                : (ncl <= `DCS_NEG_CLAMP_SELECT_MAX);

  // Bus answer; zero wait states
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit;
      if (setup & ~pwrite) begin
        prdata_q <= {16'h0000, rd_word};
      end
    end
  end

  // Writable registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_q            <= `DCS_RST_SUPPLY;
      cal_enable_q        <= 1'b0;
      gain_correction_q   <= `DCS_RST_ZERO;
      offset_correction_q <= `DCS_RST_ZERO;
      alarm_pin_masks_q   <= `DCS_RST_ZERO;
      host_toggle_bit_q   <= 1'b0;
    end else if (wr_acc) begin
      if (hit_sup) supply_q <= pwdata[5:0];
      if (hit_cal) cal_enable_q <= pwdata[0];
      if (hit_gn) gain_correction_q <= pwdata[15:0];
      if (hit_of) offset_correction_q <= pwdata[15:0];
      if (hit_mk) alarm_pin_masks_q <= pwdata[15:0];
      if (hit_us) host_toggle_bit_q <= pwdata[0];
    end
  end

  // Flags, datapath and pin outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_q      <= 4'h0;
      cal_code_q    <= `DCS_RST_ZERO;
      clamp_valid_q <= 1'b0;
      alarm_q       <= 1'b0;
    end else begin
      sticky_q      <= sticky_d;
      cal_code_q    <= cal_enable_q ? cal_sat : dac_code;
      clamp_valid_q <= clamp_ok;
      alarm_q       <= alarm_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign supply_cfg       = supply_q;
  assign cal_code         = cal_code_q;
  assign clamp_code_valid = clamp_valid_q;
  assign alarm_irq        = alarm_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr(logic h);
    wr_acc && h;
  endsequence

  sequence s_bypass;
    !cal_enable_q ##0 1'b1;
  endsequence

  // Read setup: data is captured here and shown one cycle later
  sequence s_rd(logic h);
    psel && !penable && !pwrite && h;
  endsequence

  a_clamp_volt_bad: assert property (
    voltage_mode && (ncl == 4'h3) |=> !clamp_code_valid)
    else $error("illegal voltage-mode clamp code marked valid");

  a_clamp_cur_ok: assert property (
    !voltage_mode && (ncl == 4'h9) |=> clamp_code_valid)
    else $error("legal current-mode clamp code marked invalid");

  a_arm_write: assert property (
    s_wr(hit_sup) |=> supply_cfg.arm_select == $past(pwdata[1:0]))
    else $error("arm select write not taken");

  a_cal_en_write: assert property (
    s_wr(hit_cal) |=> cal_enable_q == $past(pwdata[0]))
    else $error("calibration enable write not taken");

  a_gain_write: assert property (
    s_wr(hit_gn) |=> gain_correction_q == $past(pwdata[15:0]))
    else $error("gain write not taken");

  a_gain_read: assert property (
    s_rd(hit_gn) |=> prdata[15:0] == $past(gain_correction_q))
    else $error("gain readback mismatch");

  a_gain_hold: assert property (
    !(wr_acc && hit_gn) |=> $stable(gain_correction_q))
    else $error("gain changed without a write");

  a_offs_read: assert property (
    s_rd(hit_of) |=> prdata[15:0] == $past(offset_correction_q))
    else $error("offset readback mismatch");

  a_offs_hold: assert property (
    !(wr_acc && hit_of) |=> $stable(offset_correction_q))
    else $error("offset changed without a write");

  a_cal_read: assert property (
    s_rd(hit_cal) |=> prdata[15:0] == {15'h0000, $past(cal_enable_q)})
    else $error("calibration enable readback mismatch");

  a_cal_hold: assert property (
    !(wr_acc && hit_cal) |=> $stable(cal_enable_q))
    else $error("calibration enable changed without a write");

  a_neg_write: assert property (
    s_wr(hit_sup) |=> supply_cfg.neg_clamp_select == $past(pwdata[5:2]))
    else $error("clamp select write not taken");

  a_supply_hold: assert property (
    !(wr_acc && hit_sup) |=> $stable(supply_cfg))
    else $error("supply config changed without a write");

  a_clamp_volt_def: assert property (
    voltage_mode && (ncl == 4'h7) |=> clamp_code_valid)
    else $error("default voltage-mode clamp code marked invalid");

  a_clamp_range: assert property (
    !voltage_mode && (ncl > 4'h9) |=> !clamp_code_valid)
    else $error("out of range clamp code marked valid");

  a_offs_write: assert property (
    s_wr(hit_of) |=> offset_correction_q == $past(pwdata[15:0]))
    else $error("offset write not taken");

  a_cal_bypass: assert property (
    s_bypass |=> cal_code == $past(dac_code))
    else $error("code altered while calibration is off");

  a_learn_view: assert property (
    s_rd(hit_fl) |=> prdata[`DCS_BIT_LEARN] == $past(filt.learn_done))
    else $error("learn-done bit does not follow its level");

  a_wdt_sticky: assert property (
    sticky_q[3] && !rd_clr |=> sticky_q[3])
    else $error("watchdog flag not held");

  a_wdt_set: assert property (
    filt.watchdog |=> sticky_q[3])
    else $error("watchdog expiry not flagged");

  a_pg_view: assert property (
    s_rd(hit_fl) |=> prdata[`DCS_BIT_PG] == $past(filt.supply_good))
    else $error("power good bit wrong");

  a_toggle_echo: assert property (
    s_wr(hit_us) |=> flags_word[`DCS_BIT_TGL] == $past(pwdata[0]))
    else $error("toggle echo does not follow write");

  a_toggle_read: assert property (
    s_rd(hit_fl) |=> prdata[`DCS_BIT_TGL] == $past(host_toggle_bit_q))
    else $error("toggle echo missing from status read");

  a_crc_hold: assert property (
    sticky_q[2] && !rd_clr |=> sticky_q[2])
    else $error("integrity flag lost without a read");

  a_temp_hold: assert property (
    sticky_q[1] && !rd_clr |=> sticky_q[1])
    else $error("temperature flag lost without a read");

  // A status read that saw the fault flag clears it once the event is gone
  a_flag_clear: assert property (
    rd_clr && seen[0] && !events[0] |=> !sticky_q[0])
    else $error("fault flag not cleared by its read");

  a_crc_flag: assert property (
    filt.crc_fail |=> sticky_q[2])
    else $error("integrity error not flagged");

  a_temp_flag: assert property (
    filt.over_temp |=> sticky_q[1])
    else $error("over temperature not flagged");

  a_fault_flag: assert property (
    filt.out_fault |=> sticky_q[0])
    else $error("output fault not flagged");

  a_mask_write: assert property (
    s_wr(hit_mk) |=> alarm_pin_masks_q == $past(pwdata[15:0]))
    else $error("mask write not taken");

  a_mask_read: assert property (
    s_rd(hit_mk) |=> prdata[15:0] == $past(alarm_pin_masks_q))
    else $error("mask readback mismatch");

  a_mask_hold: assert property (
    !(wr_acc && hit_mk) |=> $stable(alarm_pin_masks_q))
    else $error("mask changed without a write");

  a_mask_block: assert property (
    (sticky_q == 4'h1) && alarm_pin_masks_q[`DCS_BIT_FAULT]
      |=> !alarm_irq)
    else $error("masked fault reached alarm pin");

  a_alarm_fault: assert property (
    sticky_q[0] && !alarm_pin_masks_q[`DCS_BIT_FAULT] |=> alarm_irq)
    else $error("unmasked fault missing from alarm pin");

  a_alarm_cause: assert property (
    alarm_irq |-> $past(|(sticky_q & ~src_mask)))
    else $error("alarm without unmasked flag");

endmodule

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the calibration and status register bank.
// Assumes a zero-wait APB slave and the condition-pin model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_params.svh"

module tb_top;
  import dcs_pkg::*;
  logic           sys_clk, rst_b, psel, penable, pwrite, voltage_mode;
  logic           pready, pslverr, alarm_irq, valid, err_q;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd_q;
  logic [15:0]    dac_code, cal_code;
  logic [5:0]     req;
  dcs_src_type    src_pins;
  dcs_supply_type supply_cfg;
  int             errors, checked;
  localparam logic [15:0] BASE = 16'h1000 | {5'h00, `DCS_IDENT_BITS, 8'h00};

  dcs_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_pins(src_pins), .voltage_mode(voltage_mode),
    .dac_code(dac_code), .cal_code(cal_code), .supply_cfg(supply_cfg),
    .clamp_code_valid(valid), .alarm_irq(alarm_irq));
  dcs_cond_model cond (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .src_pins(src_pins));

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits on pready itself, so a slower slave still passes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd_q, {16'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'h1, a, {16'h0, d});
  endtask

  task automatic pulse(input int s);
    req[s] <= 1'h1;
    repeat (5) @(posedge sys_clk);
    req[s] <= 1'h0;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic finish_test();
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #50000;
    errors++;
    finish_test();
  end

  initial begin
    int b[4] = '{11, 5, 4, 0};
    int s[4] = '{4, 2, 1, 0};
    rst_b = 1'h0;
    {psel, penable, pwrite, voltage_mode} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dac_code = 16'h0000;
    req = 6'h20;
    errors = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    chk({26'h0, supply_cfg}, 32'h1C);
    rd(8'h2C, BASE);
    rd(8'h20, 16'h0000);
    rd(8'h24, 16'h0000);
    rd(8'h28, 16'h0000);
    rd(8'h30, 16'h0000);
    wr(8'h24, 16'h8000);
    rd(8'h24, 16'h8000);
    wr(8'h28, 16'h0010);
    rd(8'h28, 16'h0010);
    dac_code <= 16'h4000;
    repeat (2) @(posedge sys_clk);
    chk({16'h0, cal_code}, 32'h4000);
    wr(8'h20, 16'h0001);
    rd(8'h20, 16'h0001);
    repeat (2) @(posedge sys_clk);
    chk({16'h0, cal_code}, 32'h2010);
    wr(8'h20, 16'h0000);
    // Unmapped place: refused, and gain left alone
    xfer(1'h1, 8'h3C, 32'hFFFF);
    chk({31'h0, err_q}, 32'h1);
    rd(8'h24, 16'h8000);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        voltage_mode <= m[0];
        wr(8'h1C, {10'h0, c[3:0], c[1:0]});
        repeat (2) @(posedge sys_clk);
        chk({31'h0, valid}, {31'h0, m ? (c == 2 || c == 7 || c == 9) : (c < 10)});
        chk({26'h0, supply_cfg}, {26'h0, c[3:0], c[1:0]});
      end
    end
    wr(8'h78, 16'h0001);
    rd(8'h2C, BASE | 16'h0040);
    wr(8'h78, 16'h0000);
    req[3] <= 1'h1;
    repeat (5) @(posedge sys_clk);
    rd(8'h2C, BASE | 16'h0080);
    req[3] <= 1'h0;
    repeat (5) @(posedge sys_clk);
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'hFFFF);
    wr(8'h30, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pulse(s[i]);
      chk({31'h0, alarm_irq}, 32'h1);
      rd(8'h2C, BASE | (16'h1 << b[i]));
      rd(8'h2C, BASE);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, alarm_irq}, 32'h0);
      wr(8'h30, 16'h1 << b[i]);
      pulse(s[i]);
      chk({31'h0, alarm_irq}, 32'h0);
      rd(8'h2C, BASE | (16'h1 << b[i]));
      wr(8'h30, 16'h0000);
    end
    // Second reset in mid-run: stored values return to defaults
    rst_b <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    chk({26'h0, supply_cfg}, 32'h1C);
    rd(8'h24, 16'h0000);
    rd(8'h28, 16'h0000);
    rd(8'h2C, BASE);
    finish_test();
  end
endmodule

`default_nettype wire
